// [humidity_readout.sv]
// Functional notes
// - Answer only slave address 0x40
// - Serial bus works up to 400 kHz
// - Control bit D0 write starts conversion
// - Status D0 high while conversion runs
// - Result high at 0x01, low 0x02
// - Code 12 bits, left justified, low zeros
// - Normal conversion takes 35 ms
// - Control D5 selects fast 18 ms mode
// - Acked read advances to next byte
//
// Top of the humidity readout: serial slave, register file, converter.
// Assumes scl and sda arrive asynchronously from the bus pins.
`timescale 1ns/1ps
`include "rh_readout_params.svh"

module humidity_readout #(
    parameter int NORMAL_CYCLES = `CONV_NORMAL_US * `CORE_CLK_MHZ,
    parameter int FAST_CYCLES = `CONV_FAST_US * `CORE_CLK_MHZ
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Serial bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Analog front end sample
    input wire logic [`CODE_WIDTH-1:0] sampleCode,
    // State views
    output logic convBusy,
    output logic fastSelected
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage one is read only by stage two
    logic [1:0] sclSync_q, sdaSync_q;
    logic sclPrev_q, sdaPrev_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sclSync_q <= 2'b11;
            sdaSync_q <= 2'b11;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclSync_q <= {sclSync_q[0], sclIn};
            sdaSync_q <= {sdaSync_q[0], sdaIn};
            sclPrev_q <= sclSync_q[1];
            sdaPrev_q <= sdaSync_q[1];
        end
    end

    logic scl, sda, sclRise, sclFall, startCond, stopCond;
    // 250 MHz oversamples a 400 kHz bus heavily, so edges are clean
    assign scl = sclSync_q[1];
    assign sda = sdaSync_q[1];
    assign sclRise = scl & ~sclPrev_q;
    assign sclFall = ~scl & sclPrev_q;
    assign startCond = scl & sclPrev_q & sdaPrev_q & ~sda;
    assign stopCond = scl & sclPrev_q & ~sdaPrev_q & sda;

    ////////////////////////////////////////////////////////////////////
    // Protocol state
    rh_readout_pkg::bus_state_type state_q, state_d;
    logic [7:0] shift_q, shift_d; // Byte shifter
    logic [3:0] bitCnt_q, bitCnt_d; // Bits done in byte
    logic [7:0] pointer_q, pointer_d; // Register pointer
    logic gotPtr_q, gotPtr_d; // Pointer byte seen this frame
    logic readDir_q, readDir_d; // Current frame is a read
    logic [7:0] control_q, control_d; // Measurement control
    logic sdaOut_q, sdaOut_d;
    logic sdaOe_q, sdaOe_d;
    logic startPulse_q, startPulse_d;
    logic fast_q;
    logic busy;
    logic [`CODE_WIDTH-1:0] code;

    // Read mux: status, left-justified code bytes
    function automatic logic [7:0] readReg(input logic [7:0] ptr);
        logic [7:0] v;
        v = `BYTE_ZERO;
        case (ptr)
            `REG_STATUS: v[`STATUS_PENDING_BIT] = busy;
            `REG_RESULT_HIGH: v = code[11:4];
            `REG_RESULT_LOW: v = {code[3:0], 4'h0};
            `REG_CONTROL: v = control_q;
            default: v = `BYTE_ZERO;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Next state of the slave and register file
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        bitCnt_d = bitCnt_q;
        pointer_d = pointer_q;
        gotPtr_d = gotPtr_q;
        readDir_d = readDir_q;
        control_d = control_q;
        sdaOut_d = sdaOut_q;
        sdaOe_d = sdaOe_q;
        startPulse_d = 1'b0;
        if (startCond) begin
            // Start or repeated start: listen for address
            state_d = rh_readout_pkg::BUS_ADDR;
            bitCnt_d = 4'h0;
            gotPtr_d = 1'b0;
            sdaOe_d = 1'b0;
        end else if (stopCond) begin
            state_d = rh_readout_pkg::BUS_IDLE;
            sdaOe_d = 1'b0;
        end else begin
            case (state_q)
                rh_readout_pkg::BUS_IDLE: begin
                    sdaOe_d = 1'b0;
                end
                rh_readout_pkg::BUS_ADDR, rh_readout_pkg::BUS_WRITE: begin
                    if (sclRise) begin
                        shift_d = {shift_q[6:0], sda};
                        bitCnt_d = bitCnt_q + 4'h1;
                    end else if (sclFall && bitCnt_q == 4'h8) begin
                        bitCnt_d = 4'h0;
                        if (state_q == rh_readout_pkg::BUS_ADDR) begin
                            if (shift_q[7:1] == `SLAVE_ADDR) begin
                                readDir_d = shift_q[0];
                                state_d = rh_readout_pkg::BUS_ACK;
                                sdaOut_d = 1'b0;
                                sdaOe_d = 1'b1;
                            end else begin
                                // Foreign address: stay off the bus
                                state_d = rh_readout_pkg::BUS_IDLE;
                            end
                        end else begin
                            state_d = rh_readout_pkg::BUS_ACK;
                            sdaOut_d = 1'b0;
                            sdaOe_d = 1'b1;
                            if (!gotPtr_q) begin
                                pointer_d = shift_q;
                                gotPtr_d = 1'b1;
                            end else if (pointer_q == `REG_CONTROL) begin
                                control_d = shift_q;
                                // Start pulse also raises pending flag
                                startPulse_d = shift_q[`CTRL_START_BIT];
                            end
                        end
                    end
                end
                rh_readout_pkg::BUS_ACK: begin
                    // Release ack after ninth clock; load read data
                    if (sclFall) begin
                        if (readDir_q) begin
                            shift_d = readReg(pointer_q);
                            // First data bit is the byte's top bit
                            sdaOut_d = shift_d[7];
                            sdaOe_d = 1'b1;
                            bitCnt_d = 4'h1;
                            state_d = rh_readout_pkg::BUS_READ;
                        end else begin
                            sdaOe_d = 1'b0;
                            state_d = rh_readout_pkg::BUS_WRITE;
                        end
                    end
                end
                rh_readout_pkg::BUS_READ: begin
                    if (sclFall) begin
                        if (bitCnt_q == 4'h8) begin
                            sdaOe_d = 1'b0;
                            state_d = rh_readout_pkg::BUS_RACK;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            sdaOut_d = shift_q[6];
                            bitCnt_d = bitCnt_q + 4'h1;
                        end
                    end
                end
                rh_readout_pkg::BUS_RACK: begin
                    if (sclRise) begin
                        if (sda) begin
                            // Master nacked: done until next start
                            state_d = rh_readout_pkg::BUS_IDLE;
                        end else begin
                            pointer_d = pointer_q + 8'h01;
                            state_d = rh_readout_pkg::BUS_ACK;
                        end
                    end
                end
                default: state_d = rh_readout_pkg::BUS_IDLE;
            endcase
        end
    end

    // Registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= rh_readout_pkg::BUS_IDLE;
            shift_q <= `BYTE_ZERO;
            bitCnt_q <= 4'h0;
            pointer_q <= `BYTE_ZERO;
            gotPtr_q <= 1'b0;
            readDir_q <= 1'b0;
            control_q <= `CONTROL_RESET;
            sdaOut_q <= 1'b1;
            sdaOe_q <= 1'b0;
            startPulse_q <= 1'b0;
            fast_q <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            bitCnt_q <= bitCnt_d;
            pointer_q <= pointer_d;
            gotPtr_q <= gotPtr_d;
            readDir_q <= readDir_d;
            control_q <= control_d;
            sdaOut_q <= sdaOut_d;
            sdaOe_q <= sdaOe_d;
            startPulse_q <= startPulse_d;
            fast_q <= control_d[`CTRL_FAST_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Conversion engine; busy is a flop inside it
    rh_converter #(
        .NORMAL_CYCLES(NORMAL_CYCLES),
        .FAST_CYCLES(FAST_CYCLES)
    ) converter (
        .core_clk(core_clk),
        .rst(rst),
        .start(startPulse_q),
        .fastMode(fast_q),
        .sampleCode(sampleCode),
        .busy(busy),
        .code(code)
    );

    // belongs to the host; the code bytes are raw
    assign sdaOut = sdaOut_q;
    assign sdaOe = sdaOe_q;
    assign convBusy = busy;
    assign fastSelected = fast_q;

endmodule

// [rh_readout_params.svh]
// Constants for the humidity readout block: address, register map,
// field positions, reset values and conversion timing.
// Assumes inclusion by bare name; definitions only.
`ifndef RH_READOUT_PARAMS_SVH
`define RH_READOUT_PARAMS_SVH

// Bus address and register pointers
`define SLAVE_ADDR 7'h40
`define REG_STATUS 8'h00
`define REG_RESULT_HIGH 8'h01
`define REG_RESULT_LOW 8'h02
`define REG_CONTROL 8'h03

// Control and status field positions
`define CTRL_START_BIT 0
`define CTRL_FAST_BIT 5
`define STATUS_PENDING_BIT 0

// Reset values and code width
`define CONTROL_RESET 8'h00
`define BYTE_ZERO 8'h00
`define CODE_WIDTH 12

// Conversion times in microseconds, clock in MHz
`define CONV_NORMAL_US 35000
`define CONV_FAST_US 18000
`define CORE_CLK_MHZ 250

`endif

// [rh_readout_pkg.sv]
// Types for the humidity readout block.
// Assumes the params header is compiled alongside.
package rh_readout_pkg;

    // Serial slave protocol states
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADDR = 3'b001,
        BUS_ACK = 3'b010,
        BUS_WRITE = 3'b011,
        BUS_READ = 3'b100,
        BUS_RACK = 3'b101
    } bus_state_type;

endpackage

// [rh_converter.sv]
// Conversion engine: runs a timed humidity conversion, yields a code.
// Assumes start is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
`include "rh_readout_params.svh"

module rh_converter #(
    parameter int NORMAL_CYCLES = `CONV_NORMAL_US * `CORE_CLK_MHZ,
    parameter int FAST_CYCLES = `CONV_FAST_US * `CORE_CLK_MHZ
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic fastMode,
    input wire logic [`CODE_WIDTH-1:0] sampleCode,
    // Results
    output logic busy,
    output logic [`CODE_WIDTH-1:0] code
);

    logic [31:0] count_q, count_d; // Remaining cycles
    logic busy_q, busy_d;
    logic [`CODE_WIDTH-1:0] code_q, code_d;

    ////////////////////////////////////////////////////////////////////
    // Next state: load timer on start, latch code on expiry
    always_comb begin
        count_d = count_q;
        busy_d = busy_q;
        code_d = code_q;
        if (start) begin
            // Restart wins over a running conversion
            busy_d = 1'b1;
            count_d = fastMode ? 32'(FAST_CYCLES) : 32'(NORMAL_CYCLES);
        end else if (busy_q) begin
            if (count_q <= 32'h0000_0001) begin
                busy_d = 1'b0;
                // Fast mode drops the lowest code bit
                code_d = fastMode ? (sampleCode & ~12'h001) : sampleCode;
            end else begin
                count_d = count_q - 32'h0000_0001;
            end
        end
    end

    // Registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count_q <= 32'h0000_0000;
            busy_q <= 1'b0;
            code_q <= 12'h000;
        end else begin
            count_q <= count_d;
            busy_q <= busy_d;
            code_q <= code_d;
        end
    end

    assign busy = busy_q;
    assign code = code_q;

endmodule

// [rh_bus_host.sv]
// Bus master model driving the humidity readout from the host side.
// Assumes the bench folds sdaDrv into an open-drain, pulled-up line.
`timescale 1ns/1ps
module rh_bus_host #(
    parameter int QUARTER = 157
) (
    // Clock
    input wire logic core_clk,
    // Bus lines
    input wire logic sdaLine,
    output logic scl,
    output logic sdaDrv
);
    // Idle bus: both lines released high
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    // One quarter bit; 628 cycles a bit keeps the rate under 400 kHz
    task automatic put(input logic c, input logic d);
        scl <= c;
        sdaDrv <= d;
        repeat (QUARTER) @(posedge core_clk);
    endtask
    // Start, also used as repeated start
    task automatic start();
        put(scl, 1'b1);
        put(1'b1, 1'b1);
        put(1'b1, 1'b0);
        put(1'b0, 1'b0);
    endtask
    // Stop: data rises while the clock is high
    task automatic stop();
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
    endtask
    // One bit; line sampled in the middle of the high phase
    task automatic xbit(input logic b, output logic r);
        put(1'b0, b);
        put(1'b1, b);
        r = sdaLine;
        put(1'b1, b);
        put(1'b0, b);
    endtask
    // Byte out, acknowledge bit back
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r);
        end
        xbit(1'b1, ack);
    endtask
    // Byte in; ack asks for the next byte, last one is refused
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r);
            d[i] = r;
        end
        xbit(last, r);
    endtask
    // Host scaling of the 12-bit code to percent
    function automatic int rhPct(input logic [11:0] code);
        return code / 16 - 24;
    endfunction
endmodule

// [humidity_readout_assertions.sv]
// Checker for the humidity readout: bus pin timing, conversion spans.
// Assumes a bind into humidity_readout; one clock, sync reset.
`timescale 1ns/1ps
`include "rh_readout_params.svh"
module humidity_readout_assertions #(
    parameter int NORMAL_CYCLES = 200,
    parameter int FAST_CYCLES = 100
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // Sample and state views
    input wire logic [`CODE_WIDTH-1:0] sampleCode,
    input wire logic convBusy,
    input wire logic fastSelected
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////
    // Busy cycle count; int so long counts never wrap
    int busyCnt_q;
    int busyCnt_d;
    always_comb begin
        busyCnt_d = convBusy ? busyCnt_q + 1 : 0;
    end
    always_ff @(posedge core_clk) begin
        busyCnt_q <= rst ? 0 : busyCnt_d;
    end
    ////////////////////////////////////////////////////////////////////
    property p_resetQuiet;
        $fell(rst) |-> !sdaOe && !convBusy && !fastSelected;
    endproperty
    a_resetQuiet: assert property (p_resetQuiet)
        else $error("outputs active after reset");
    property p_sdaHold;
        sclIn [*5] |-> $stable(sdaOe) && (!sdaOe || $stable(sdaOut));
    endproperty
    a_sdaHold: assert property (p_sdaHold)
        else $error("data moved while clock high");
    property p_oeEdges;
        $rose(sdaOe) || $fell(sdaOe) |-> !sclIn;
    endproperty
    a_oeEdges: assert property (p_oeEdges)
        else $error("drive toggled while clock high");
    property p_startFree;
        sclIn && $fell(sdaIn) |=> !sdaOe [*8];
    endproperty
    a_startFree: assert property (p_startFree)
        else $error("line driven during address");
    property p_busyAtAck;
        $rose(convBusy) |-> sdaOe && !sdaOut;
    endproperty
    a_busyAtAck: assert property (p_busyAtAck)
        else $error("busy rose outside control ack");
    property p_fastAtAck;
        $changed(fastSelected) |-> sdaOe && !sdaOut;
    endproperty
    a_fastAtAck: assert property (p_fastAtAck)
        else $error("fast mode moved outside ack");
    property p_normalLen;
        $fell(convBusy) && !fastSelected |-> busyCnt_q >= NORMAL_CYCLES - 1
            && busyCnt_q <= NORMAL_CYCLES + 1;
    endproperty
    a_normalLen: assert property (p_normalLen)
        else $error("normal conversion length wrong");
    property p_fastLen;
        $fell(convBusy) && fastSelected |-> busyCnt_q >= FAST_CYCLES - 1
            && busyCnt_q <= FAST_CYCLES + 1;
    endproperty
    a_fastLen: assert property (p_fastLen)
        else $error("fast conversion length wrong");
endmodule
bind humidity_readout humidity_readout_assertions #(
    .NORMAL_CYCLES(NORMAL_CYCLES), .FAST_CYCLES(FAST_CYCLES)) u_chk (
    .core_clk(core_clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .sampleCode(sampleCode),
    .convBusy(convBusy), .fastSelected(fastSelected));

// [tb.sv]
// Testbench: start and read conversions over the serial bus, waiting on convBusy.
// Assumes the host model and the checker compile alongside.
`timescale 1ns/1ps
`include "rh_readout_params.svh"
module tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [`CODE_WIDTH-1:0] sampleCode = 12'h5E7;
    logic scl, sdaDrv, sdaLine, sdaOut, sdaOe, convBusy, fastSelected;
    int error_cnt = 0;
    int n_compared = 0;
    always #2 core_clk = ~core_clk;
    // Open-drain line: anyone pulling low wins, else pull-up
    assign sdaLine = sdaDrv & (sdaOe ? sdaOut : 1'b1);
    // Short conversions keep the run small
    humidity_readout #(.NORMAL_CYCLES(2000), .FAST_CYCLES(1000)) u_dut (
        .core_clk(core_clk), .rst(rst), .sclIn(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .sampleCode(sampleCode),
        .convBusy(convBusy), .fastSelected(fastSelected));
    rh_bus_host u_host (.core_clk(core_clk), .sdaLine(sdaLine),
        .scl(scl), .sdaDrv(sdaDrv));
    ////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Address for write, then the register pointer
    task automatic point(input logic [7:0] ptr);
        logic a;
        u_host.start();
        u_host.wbyte(8'h80, a);
        chk(8'(a), 8'h00);
        u_host.wbyte(ptr, a);
        chk(8'(a), 8'h00);
    endtask
    // Control write; busy and mode must show before the stop
    task automatic wreg(input logic [7:0] ptr, input logic [7:0] d);
        logic a;
        point(ptr);
        u_host.wbyte(d, a);
        chk(8'(a), 8'h00);
        chk(8'(convBusy), 8'(d[0]));
        chk(8'(fastSelected), 8'(d[5]));
        u_host.stop();
    endtask
    // Pointer, repeated start, then n bytes in order
    task automatic rd(input logic [7:0] ptr, input int n,
        output logic [7:0] b [3]);
        logic a;
        point(ptr);
        u_host.start();
        u_host.wbyte(8'h81, a);
        chk(8'(a), 8'h00);
        for (int i = 0; i < n; i++) begin
            u_host.rbyte(i == n - 1, b[i]);
        end
        u_host.stop();
    endtask
    // Bounded wait for the conversion to finish
    task automatic waitIdle();
        int k;
        k = 0;
        while (convBusy !== 1'b0 && k < 5000) begin
            @(posedge core_clk);
            k++;
        end
        if (k == 5000) begin
            error_cnt++;
            summarize();
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic a;
        logic [7:0] b [3];
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (8) @(posedge core_clk);
        wreg(`REG_CONTROL, 8'h01);
        waitIdle();
        rd(`REG_STATUS, 3, b);
        chk(b[0], 8'h00);
        chk(b[1], 8'h5E);
        chk(b[2], 8'h70);
        chk(8'(u_host.rhPct({b[1], b[2][7:4]})), 8'h46);
        // Fast mode drops the code's lowest bit
        sampleCode <= 12'h7C3;
        wreg(`REG_CONTROL, 8'h21);
        waitIdle();
        rd(`REG_RESULT_LOW, 1, b);
        chk(b[0], 8'h20);
        // Foreign address: no acknowledge expected
        u_host.start();
        u_host.wbyte(8'h82, a);
        u_host.stop();
        chk(8'(a), 8'h01);
        summarize();
    end
endmodule
